// ### hdl/ethbuf_pkg.sv
package ethbuf_pkg;

  // register offsets on the special function register port
  localparam logic [7:0] DATA_PORT_ADDR  = 8'hE6;
  localparam logic [7:0] CMD_STATUS_ADDR = 8'hE7;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hE8;

  // reset values
  localparam logic [7:0] DATA_PORT_RST   = 8'h00;
  localparam logic [7:0] CMD_STATUS_RST  = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // field positions in buffer_command_status
  localparam int BUSY_BIT      = 7;
  localparam int WAKE_BIT      = 6;
  localparam int TX_BIT        = 5;
  localparam int RX_BIT        = 4;
  localparam int CMD_HI        = 3;
  localparam int CMD_LO        = 0;

  // field positions in extended_interrupt_enable
  localparam int WAKE_IE_BIT   = 7;
  localparam int ACT_IE_BIT    = 5;

  // command codes
  localparam logic [3:0] CMD_NOP        = 4'h0;
  localparam logic [3:0] CMD_INVALIDATE = 4'h2;
  localparam logic [3:0] CMD_FLUSH      = 4'h3;
  localparam logic [3:0] CMD_TX_NORMAL  = 4'h4;
  localparam logic [3:0] CMD_TX_NOPAD   = 4'h5;
  localparam logic [3:0] CMD_CSR_WRITE  = 4'h8;
  localparam logic [3:0] CMD_CSR_READ   = 4'h9;
  localparam logic [3:0] CMD_SLEEP_ON   = 4'hC;
  localparam logic [3:0] CMD_SLEEP_OFF  = 4'hD;

  // transmit descriptor staging memory
  localparam int         DESC_DEPTH    = 4;
  localparam logic [1:0] DESC_COUNT_LO = 2'h0;
  localparam logic [1:0] DESC_COUNT_HI = 2'h1;
  localparam logic [1:0] DESC_PAGE     = 2'h2;
  localparam int         COUNT_HI_W    = 3;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_TX_RD0   = 3'b001,
    ST_TX_RD1   = 3'b010,
    ST_TX_RD2   = 3'b011,
    ST_TX_GO    = 3'b100,
    ST_CSR_WAIT = 3'b101
  } unit_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic        pad_disable;
    logic [10:0] byte_count;
    logic [7:0]  start_page;
  } tx_desc_t;

endpackage

// ### hdl/desc_mem.sv
`timescale 1ns/1ps
module desc_mem
  import ethbuf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [1:0] rd_addr,
  output logic      [7:0] rd_data_q
);

  logic [7:0] mem [DESC_DEPTH];

  genvar i;
  generate
    for (i = 0; i < DESC_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
        if (wr_en && (wr_addr == 2'(i))) begin
          mem[i] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule

// ### hdl/ethbuf_cmd_if.sv
`timescale 1ns/1ps
// Contract
// - load byte count and page before transmit
// - data port reads show current receive page, or the config read data once after a config read
// - busy bit tracks config access, read-only
// - wake event sets sticky power flag
// - software setting power flag raises interrupt
// - transmit status stored sets transmit flag
// - receive status stored sets receive flag
// - invalidate sets receive flag if it is clear and fifo holds more than one entry, clears it if one
// - hardware clears receive flag on emptying events
// - software setting activity flags raises interrupt
// - code zero no-op, reserved codes ignored
// - 0010 discards packet, 0011 flushes buffer
// - 0100 normal transmit, 0101 no padding
// - 1000 config write, 1001 config read
// - 1100 enters sleep, 1101 leaves sleep
// - activity enable gates receive/transmit interrupt
// - failed filtered frame never sets receive flag while failed_packet_flush_enable is set
module ethbuf_cmd_if
  import ethbuf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire sfr_req_t   sfr_req,
  output logic      [7:0] sfr_rdata_q,
  input  wire logic [7:0] rx_page_info,
  input  wire logic       rx_status_stored,
  input  wire logic       rx_filter_fail,
  input  wire logic       failed_packet_flush_enable,
  input  wire logic       rx_fifo_empty,
  input  wire logic       rx_fifo_single,
  input  wire logic       tx_status_stored,
  input  wire logic       wake_detect,
  input  wire logic       buffer_size_write,
  input  wire logic       csr_done,
  input  wire logic [7:0] csr_rdata,
  output logic            invalidate_q,
  output logic            flush_q,
  output logic            tx_start_q,
  output tx_desc_t        tx_desc_q,
  output logic            csr_write_q,
  output logic            csr_read_q,
  output logic      [7:0] csr_wdata_q,
  output logic            sleep_q,
  output logic            irq_activity_q,
  output logic            irq_power_q
);

  unit_state_t state_q;
  logic [7:0]  irq_enable_q;
  logic [3:0]  cmd_field_q;
  logic        busy_q;
  logic        wake_flag_q;
  logic        tx_flag_q;
  logic        rx_flag_q;
  logic        fifo_empty_prev_q;
  logic        show_csr_q;
  logic        csr_is_rd_q;
  logic [7:0]  csr_latch_q;
  logic [1:0]  load_ptr_q;
  logic        pad_off_q;
  logic [7:0]  mem_rdata;
  logic [1:0]  mem_raddr;
  logic        wr_data_port;
  logic        wr_cmd;
  logic        wr_irq_en;
  logic        rd_data_port;
  logic        launch;
  logic [3:0]  wcmd;
  logic        rx_set;
  logic        rx_clr;

  assign wr_data_port = sfr_req.wr && (sfr_req.addr == DATA_PORT_ADDR);
  assign wr_cmd       = sfr_req.wr && (sfr_req.addr == CMD_STATUS_ADDR);
  assign wr_irq_en    = sfr_req.wr && (sfr_req.addr == IRQ_ENABLE_ADDR);
  assign rd_data_port = sfr_req.rd && (sfr_req.addr == DATA_PORT_ADDR);
  assign wcmd         = sfr_req.wdata[CMD_HI:CMD_LO];
  // commands are accepted only when the sequencer is idle, so one write is one launch
  assign launch       = wr_cmd && (state_q == ST_IDLE);

  // receive flag set and clear terms; set wins when both land together
  always_comb begin
    rx_set = rx_status_stored && !(failed_packet_flush_enable && rx_filter_fail);
    if (launch && wcmd == CMD_INVALIDATE && !rx_fifo_empty && !rx_fifo_single
        && !rx_flag_q) begin
      rx_set = 1'b1;
    end
    rx_clr = (rx_fifo_empty && !fifo_empty_prev_q) || buffer_size_write;
    if (launch && (wcmd == CMD_FLUSH || (wcmd == CMD_INVALIDATE && rx_fifo_single))) begin
      rx_clr = 1'b1;
    end
  end

  always_comb begin
    case (state_q)
      ST_TX_RD1: mem_raddr = DESC_COUNT_HI;
      ST_TX_RD2: mem_raddr = DESC_PAGE;
      default:   mem_raddr = DESC_COUNT_LO;
    endcase
  end

  // transmit descriptor bytes land here in count-low, count-high, page order
  desc_mem u_desc_mem (
    .clk       (clk),
    .reset     (reset),
    .wr_en     (wr_data_port && state_q == ST_IDLE),
    .wr_addr   (load_ptr_q),
    .wr_data   (sfr_req.wdata),
    .rd_addr   (mem_raddr),
    .rd_data_q (mem_rdata)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      load_ptr_q <= DESC_COUNT_LO;
    end else if (launch && (wcmd == CMD_TX_NORMAL || wcmd == CMD_TX_NOPAD)) begin
      load_ptr_q <= DESC_COUNT_LO;
    end else if (wr_data_port && state_q == ST_IDLE) begin
      load_ptr_q <= (load_ptr_q == DESC_PAGE) ? DESC_COUNT_LO : load_ptr_q + 2'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q      <= ST_IDLE;
      pad_off_q    <= 1'b0;
      tx_start_q   <= 1'b0;
      tx_desc_q    <= '0;
      invalidate_q <= 1'b0;
      flush_q      <= 1'b0;
      csr_write_q  <= 1'b0;
      csr_read_q   <= 1'b0;
      busy_q       <= 1'b0;
    end else begin
      tx_start_q   <= 1'b0;
      invalidate_q <= 1'b0;
      flush_q      <= 1'b0;
      csr_write_q  <= 1'b0;
      csr_read_q   <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            case (wcmd)
              CMD_INVALIDATE: invalidate_q <= 1'b1;
              CMD_FLUSH:      flush_q <= 1'b1;
              CMD_TX_NORMAL, CMD_TX_NOPAD: begin
                pad_off_q <= (wcmd == CMD_TX_NOPAD);
                state_q   <= ST_TX_RD0;
              end
              CMD_CSR_WRITE, CMD_CSR_READ: begin
                csr_write_q <= (wcmd == CMD_CSR_WRITE);
                csr_read_q  <= (wcmd == CMD_CSR_READ);
                busy_q      <= 1'b1;
                state_q     <= ST_CSR_WAIT;
              end
              default: ; // no-op and reserved codes do nothing
            endcase
          end
        end
        ST_TX_RD0: state_q <= ST_TX_RD1;
        ST_TX_RD1: begin
          tx_desc_q.byte_count[7:0] <= mem_rdata;
          state_q <= ST_TX_RD2;
        end
        ST_TX_RD2: begin
          tx_desc_q.byte_count[10:8] <= mem_rdata[COUNT_HI_W-1:0];
          state_q <= ST_TX_GO;
        end
        ST_TX_GO: begin
          tx_desc_q.start_page  <= mem_rdata;
          tx_desc_q.pad_disable <= pad_off_q;
          tx_start_q            <= 1'b1;
          state_q               <= ST_IDLE;
        end
        ST_CSR_WAIT: begin
          if (csr_done) begin
            busy_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // config data travels through the data port in both directions
  always_ff @(posedge clk) begin
    if (reset) begin
      csr_wdata_q <= DATA_PORT_RST;
      csr_latch_q <= DATA_PORT_RST;
      show_csr_q  <= 1'b0;
      csr_is_rd_q <= 1'b0;
    end else begin
      if (wr_data_port) begin
        csr_wdata_q <= sfr_req.wdata;
      end
      // the launch pulses are long gone when csr_done arrives, so keep the direction
      if (launch) begin
        csr_is_rd_q <= (wcmd == CMD_CSR_READ);
      end
      if (state_q == ST_CSR_WAIT && csr_done && csr_is_rd_q) begin
        csr_latch_q <= csr_rdata;
        show_csr_q  <= 1'b1;
      end else if (rd_data_port || launch) begin
        show_csr_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_q <= 1'b0;
    end else if (launch && wcmd == CMD_SLEEP_ON) begin
      sleep_q <= 1'b1;
    end else if (launch && wcmd == CMD_SLEEP_OFF) begin
      sleep_q <= 1'b0;
    end
  end

  // status flags: software writes any value, hardware set beats the write
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_flag_q       <= 1'b0;
      tx_flag_q         <= 1'b0;
      rx_flag_q         <= 1'b0;
      fifo_empty_prev_q <= 1'b1;
      cmd_field_q       <= CMD_STATUS_RST[CMD_HI:CMD_LO];
    end else begin
      fifo_empty_prev_q <= rx_fifo_empty;
      if (wr_cmd) begin
        wake_flag_q <= sfr_req.wdata[WAKE_BIT];
        tx_flag_q   <= sfr_req.wdata[TX_BIT];
        rx_flag_q   <= sfr_req.wdata[RX_BIT];
        if (launch) begin
          cmd_field_q <= wcmd;
        end
      end
      if (rx_clr) begin
        rx_flag_q <= 1'b0;
      end
      if (wake_detect) begin
        wake_flag_q <= 1'b1;
      end
      if (tx_status_stored) begin
        tx_flag_q <= 1'b1;
      end
      if (rx_set) begin
        rx_flag_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_enable_q <= IRQ_ENABLE_RST;
    end else if (wr_irq_en) begin
      irq_enable_q <= sfr_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_power_q    <= 1'b0;
      irq_activity_q <= 1'b0;
    end else begin
      irq_power_q    <= irq_enable_q[WAKE_IE_BIT] && wake_flag_q;
      irq_activity_q <= irq_enable_q[ACT_IE_BIT] && (rx_flag_q || tx_flag_q);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata_q <= READ_UNMAPPED;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        DATA_PORT_ADDR:  sfr_rdata_q <= show_csr_q ? csr_latch_q : rx_page_info;
        CMD_STATUS_ADDR: sfr_rdata_q <= {busy_q, wake_flag_q, tx_flag_q, rx_flag_q,
                                         cmd_field_q};
        IRQ_ENABLE_ADDR: sfr_rdata_q <= irq_enable_q;
        default:         sfr_rdata_q <= READ_UNMAPPED;
      endcase
    end
  end

  // assertions
  property p_busy_tracks;
    @(posedge clk) disable iff (reset)
      busy_q == (state_q == ST_CSR_WAIT);
  endproperty
  a_busy_tracks: assert property (p_busy_tracks) else $error("busy mismatch");

  property p_busy_release;
    @(posedge clk) disable iff (reset)
      (state_q == ST_CSR_WAIT && csr_done) |=> !busy_q;
  endproperty
  a_busy_release: assert property (p_busy_release) else $error("busy stuck");

  property p_wake_set;
    @(posedge clk) disable iff (reset)
      wake_detect |=> wake_flag_q;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

  property p_tx_set;
    @(posedge clk) disable iff (reset)
      tx_status_stored |=> tx_flag_q;
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx flag not set");

  property p_rx_fail_drop;
    @(posedge clk) disable iff (reset)
      (!rx_flag_q && rx_status_stored && failed_packet_flush_enable && rx_filter_fail
       && !launch && !wr_cmd) |=> !rx_flag_q;
  endproperty
  a_rx_fail_drop: assert property (p_rx_fail_drop) else $error("failed frame flagged");

  property p_flush_clears;
    @(posedge clk) disable iff (reset)
      (launch && wcmd == CMD_FLUSH && !rx_status_stored) |=> !rx_flag_q;
  endproperty
  a_flush_clears: assert property (p_flush_clears) else $error("flush kept rx flag");

  property p_act_irq;
    @(posedge clk) disable iff (reset)
      (tx_flag_q && irq_enable_q[ACT_IE_BIT]) |=> irq_activity_q;
  endproperty
  a_act_irq: assert property (p_act_irq) else $error("activity irq missing");

  property p_pwr_gate;
    @(posedge clk) disable iff (reset)
      !irq_enable_q[WAKE_IE_BIT] |=> !irq_power_q;
  endproperty
  a_pwr_gate: assert property (p_pwr_gate) else $error("power irq not gated");

  property p_tx_seq;
    @(posedge clk) disable iff (reset)
      (launch && wcmd == CMD_TX_NORMAL) |=> !tx_start_q [*4] ##1 tx_start_q ##1 !tx_start_q;
  endproperty
  a_tx_seq: assert property (p_tx_seq) else $error("transmit launch timing");

  property p_reserved;
    @(posedge clk) disable iff (reset)
      (launch && wcmd == 4'hF) |=> (state_q == ST_IDLE && !invalidate_q && !flush_q);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");

  c_tx:    cover property (@(posedge clk) disable iff (reset) tx_start_q);
  c_csr:   cover property (@(posedge clk) disable iff (reset) busy_q ##[1:20] !busy_q);
  c_inval: cover property (@(posedge clk) disable iff (reset) invalidate_q ##1 rx_flag_q);
  c_wake:  cover property (@(posedge clk) disable iff (reset) irq_power_q);

endmodule

// ### dv/tb_ethbuf_cmd_if.sv
`timescale 1ns/1ps
module tb_ethbuf_cmd_if
  import ethbuf_pkg::*;
;
  logic       clk;
  logic       reset;
  sfr_req_t   sfr_req;
  logic [7:0] sfr_rdata_q;
  logic [7:0] rx_page_info;
  logic [7:0] csr_rdata;
  logic [7:0] csr_wdata_q;
  logic [4:0] pls;
  logic       rx_filter_fail;
  logic       fp_flush_en;
  logic       rx_fifo_empty;
  logic       rx_fifo_single;
  logic       invalidate_q;
  logic       flush_q;
  logic       tx_start_q;
  tx_desc_t   tx_desc_q;
  logic       csr_write_q;
  logic       csr_read_q;
  logic       sleep_q;
  logic       irq_activity_q;
  logic       irq_power_q;
  logic [7:0] rv;
  int         errors;
  int         n_tests;
  int         cyc;
  int         n_inv;
  int         n_flush;
  int         n_tx;
  int         n_cw;
  int         n_cr;

  ethbuf_cmd_if dut (
    .clk                        (clk),
    .reset                      (reset),
    .sfr_req                    (sfr_req),
    .sfr_rdata_q                (sfr_rdata_q),
    .rx_page_info               (rx_page_info),
    .rx_status_stored           (pls[0]),
    .rx_filter_fail             (rx_filter_fail),
    .failed_packet_flush_enable (fp_flush_en),
    .rx_fifo_empty              (rx_fifo_empty),
    .rx_fifo_single             (rx_fifo_single),
    .tx_status_stored           (pls[1]),
    .wake_detect                (pls[2]),
    .buffer_size_write          (pls[4]),
    .csr_done                   (pls[3]),
    .csr_rdata                  (csr_rdata),
    .invalidate_q               (invalidate_q),
    .flush_q                    (flush_q),
    .tx_start_q                 (tx_start_q),
    .tx_desc_q                  (tx_desc_q),
    .csr_write_q                (csr_write_q),
    .csr_read_q                 (csr_read_q),
    .csr_wdata_q                (csr_wdata_q),
    .sleep_q                    (sleep_q),
    .irq_activity_q             (irq_activity_q),
    .irq_power_q                (irq_power_q)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test();
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one idle cycle between accesses keeps every drive to a single edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    sfr_req <= '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    sfr_req <= '0;
    #1;
    rv = sfr_rdata_q;
    chk(rv & m, e);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    pls[i] <= 1'b1;
    @(posedge clk);
    pls[i] <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (reset) begin
      n_inv = 0;
      n_flush = 0;
      n_tx = 0;
      n_cw = 0;
      n_cr = 0;
    end else begin
      n_inv += int'(invalidate_q);
      n_flush += int'(flush_q);
      n_tx += int'(tx_start_q);
      n_cw += int'(csr_write_q);
      n_cr += int'(csr_read_q);
    end
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    logic [3:0] rsv [7];
    rsv = '{4'h1, 4'h6, 4'h7, 4'hA, 4'hB, 4'hE, 4'hF};
    reset = 1'b1;
    sfr_req = '0;
    pls = '0;
    rx_page_info = 8'h00;
    csr_rdata = 8'h00;
    rx_filter_fail = 1'b0;
    fp_flush_en = 1'b0;
    rx_fifo_empty = 1'b1;
    rx_fifo_single = 1'b0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rx_fifo_empty <= 1'b0;
    rdc(DATA_PORT_ADDR, 8'hFF, DATA_PORT_RST);
    @(posedge clk) rx_page_info <= 8'h3C;
    rdc(CMD_STATUS_ADDR, 8'hFF, CMD_STATUS_RST);
    rdc(IRQ_ENABLE_ADDR, 8'hFF, IRQ_ENABLE_RST);
    rdc(8'hE9, 8'hFF, READ_UNMAPPED);
    wr(IRQ_ENABLE_ADDR, 8'hFF);
    rdc(IRQ_ENABLE_ADDR, 8'hFF, 8'hFF);
    wr(CMD_STATUS_ADDR, 8'h80);
    rdc(CMD_STATUS_ADDR, 8'hFF, 8'h00);
    foreach (rsv[i]) wr(CMD_STATUS_ADDR, {4'h0, rsv[i]});
    settle();
    chk(n_inv + n_flush + n_tx + n_cw + n_cr, 0);
    chk(sleep_q, 1'b0);
    pulse(0);
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h10);
    chk(irq_activity_q, 1'b1);
    @(posedge clk) rx_fifo_empty <= 1'b1;
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h00);
    @(posedge clk) rx_fifo_empty <= 1'b0;
    pulse(0);
    pulse(4);
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h00);
    chk(irq_activity_q, 1'b0);
    @(posedge clk) fp_flush_en <= 1'b1;
    rx_filter_fail <= 1'b1;
    pulse(0);
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h00);
    @(posedge clk) rx_filter_fail <= 1'b0;
    wr(CMD_STATUS_ADDR, 8'h00);
    wr(CMD_STATUS_ADDR, {4'h0, CMD_INVALIDATE});
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h10);
    chk(n_inv, 1);
    @(posedge clk) rx_fifo_single <= 1'b1;
    wr(CMD_STATUS_ADDR, {4'h1, CMD_INVALIDATE});
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h00);
    chk(n_inv, 2);
    @(posedge clk) rx_fifo_single <= 1'b0;
    pulse(0);
    wr(CMD_STATUS_ADDR, {4'h1, CMD_FLUSH});
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h00);
    chk(n_flush, 1);
    pulse(1);
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h20);
    chk(irq_activity_q, 1'b1);
    wr(IRQ_ENABLE_ADDR, 8'hDF);
    settle();
    chk(irq_activity_q, 1'b0);
    wr(CMD_STATUS_ADDR, 8'h00);
    wr(IRQ_ENABLE_ADDR, 8'hFF);
    wr(CMD_STATUS_ADDR, 8'h30);
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h30);
    chk(irq_activity_q, 1'b1);
    wr(CMD_STATUS_ADDR, 8'h00);
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h00);
    pulse(2);
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h40);
    chk(irq_power_q, 1'b1);
    wr(IRQ_ENABLE_ADDR, 8'h7F);
    settle();
    chk(irq_power_q, 1'b0);
    rdc(CMD_STATUS_ADDR, 8'hF0, 8'h40);
    wr(CMD_STATUS_ADDR, 8'h00);
    wr(IRQ_ENABLE_ADDR, 8'h80);
    wr(CMD_STATUS_ADDR, 8'h40);
    settle();
    chk(irq_power_q, 1'b1);
    wr(CMD_STATUS_ADDR, 8'h00);
    for (int pd = 0; pd < 2; pd++) begin
      wr(DATA_PORT_ADDR, 8'h34);
      wr(DATA_PORT_ADDR, 8'h05);
      wr(DATA_PORT_ADDR, 8'h7A + 8'(pd));
      wr(CMD_STATUS_ADDR, pd[0] ? {4'h0, CMD_TX_NOPAD} : {4'h0, CMD_TX_NORMAL});
      repeat (8) @(posedge clk);
      #1;
      chk(n_tx, pd + 1);
      chk(tx_desc_q, {pd[0], 11'h534, 8'h7A + 8'(pd)});
    end
    wr(DATA_PORT_ADDR, 8'h5C);
    wr(CMD_STATUS_ADDR, {4'h0, CMD_CSR_WRITE});
    rdc(CMD_STATUS_ADDR, 8'h80, 8'h80);
    chk(n_cw, 1);
    chk(csr_wdata_q, 8'h5C);
    // a second launch while busy must be dropped
    wr(CMD_STATUS_ADDR, {4'h0, CMD_CSR_WRITE});
    settle();
    chk(n_cw, 1);
    pulse(3);
    rdc(CMD_STATUS_ADDR, 8'h80, 8'h00);
    rdc(DATA_PORT_ADDR, 8'hFF, 8'h3C);
    wr(CMD_STATUS_ADDR, {4'h0, CMD_CSR_READ});
    settle();
    chk(n_cr, 1);
    @(posedge clk) csr_rdata <= 8'hA5;
    pulse(3);
    rdc(DATA_PORT_ADDR, 8'hFF, 8'hA5);
    rdc(DATA_PORT_ADDR, 8'hFF, 8'h3C);
    wr(CMD_STATUS_ADDR, {4'h0, CMD_SLEEP_ON});
    settle();
    chk(sleep_q, 1'b1);
    wr(CMD_STATUS_ADDR, {4'h0, CMD_SLEEP_OFF});
    settle();
    chk(sleep_q, 1'b0);
    end_of_test();
  end
endmodule
